// ===== lcs_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH

`define LCS_ADDR_W          8
`define LCS_DATA_W          8

`define LCS_ADDR_LINE_CFG   8'h07
`define LCS_ADDR_FRAME_CFG  8'h0C
`define LCS_ADDR_PSAVE_CFG  8'h1A
`define LCS_ADDR_PSAVE_STAT 8'h2C
`define LCS_ADDR_PAL_BASE   8'h30
`define LCS_PAL_MASK        8'hFC

`define LCS_POL_BIT         6
`define LCS_SWSUSP_BIT      7
`define LCS_REFSEL_LO       0
`define LCS_REFSEL_HI       1

`define LCS_PSAVE_CFG_RST   8'h00
`define LCS_POL_CFG_RST     8'h00

`define LCS_RESUME_NS       40
`define LCS_CLK_PERIOD_NS   4
`define LCS_RESUME_CYC      ((`LCS_RESUME_NS + `LCS_CLK_PERIOD_NS - 1) / `LCS_CLK_PERIOD_NS)

`endif

// ===== lcs_pkg.sv
// types shared by the suspend control block
package lcs_pkg;

    typedef enum logic [2:0] {
        LCS_ST_NORMAL = 3'h1,
        LCS_ST_SW     = 3'h2,
        LCS_ST_HW     = 3'h4
    } lcs_state_type;

    typedef enum logic [1:0] {
        LCS_REF_CBR  = 2'h0,
        LCS_REF_SELF = 2'h1,
        LCS_REF_NONE = 2'h2,
        LCS_REF_RSVD = 2'h3
    } lcs_refresh_type;

endpackage

// ===== lcs_reg_store.sv
// byte-wide register store with registered read data
`timescale 1ns/10ps
module lcs_reg_store #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          sys_clk,
    input  wire logic          resetn,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    // refuse sizes the store cannot serve
    if (AW < 1 || AW > 12 || DW < 1) begin : g_bad_size
        $error("lcs_reg_store: unsupported size");
    end

    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rd_data_r;

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_r <= '0;
        end else if (rd_en) begin
            rd_data_r <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_r;
endmodule // lcs_reg_store

// ===== lcs_suspend_ctl.sv
// power save state control for the panel and crt display controller
`timescale 1ns/10ps
`include "lcs_map.svh"

// Summary of operation
// R1 - normal, software suspend, hardware suspend states
// R2 - hardware suspend refuses all register access
// R3 - software suspend refuses only palette registers
// R4 - display memory access only when normal
// R5 - panel data driven low in suspend
// R6 - panel power off in suspend, on otherwise
// R7 - crt outputs disabled in suspend
// R8 - hw suspend cbr: only memory interface runs
// R9 - hw suspend self/no refresh: everything stops
// R10 - sw suspend cbr: host and memory run
// R11 - sw suspend self/no refresh: host runs
// R12 - refresh scheme selectable; suspend dram refresh only
// R13 - frame/line pulses held at inactive polarity
// R14 - palette strobes kept, pixel clock stopped
// R15 - host outputs only for allowed accesses
// R16 - resume restarts everything, registers kept
module lcs_suspend_ctl
    import lcs_pkg::*;
#(
    parameter int PANEL_W = 16,
    parameter int PAL_W   = 8
) (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    // register port
    input  wire logic [`LCS_ADDR_W-1:0] reg_addr,
    input  wire logic [`LCS_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [`LCS_DATA_W-1:0] reg_rdata,
    output logic                        host_out_en,
    // system suspend request
    input  wire logic                   hw_suspend_req,
    // display memory requests
    input  wire logic                   host_mem_req,
    output logic                        host_mem_grant,
    output logic                        host_mem_refused,
    // panel path from display pipeline
    input  wire logic [PANEL_W-1:0]     pipe_panel_data,
    input  wire logic                   pipe_frame_pulse,
    input  wire logic                   pipe_line_pulse,
    output logic      [PANEL_W-1:0]     panel_data,
    output logic                        panel_frame_pulse,
    output logic                        panel_line_pulse,
    output logic                        panel_power_control,
    output logic                        display_active,
    // crt and palette converter
    output logic                        crt_out_en,
    output logic                        palette_write_strobe_n,
    output logic                        palette_read_strobe_n,
    output logic                        palette_reg_select0,
    output logic                        palette_reg_select1,
    output logic      [PAL_W-1:0]       palette_wdata,
    input  wire logic [PAL_W-1:0]       palette_rdata,
    output logic                        palette_pixel_clock,
    // module and clock enables
    output logic                        core_clk_en,
    output logic                        host_if_clk_en,
    output logic                        mem_if_clk_en,
    // dram control
    output logic                        dram_refresh_only,
    output logic                        dram_cbr_refresh,
    output logic                        dram_self_refresh,
    output lcs_state_type               power_save_state
);
    // refuse widths the panel and palette paths cannot serve
    if (PANEL_W < 1 || PANEL_W > 16 || PAL_W != `LCS_DATA_W) begin : g_bad_w
        $error("lcs_suspend_ctl: unsupported width");
    end

    localparam int RESUME_CYC = `LCS_RESUME_CYC;
    localparam logic [3:0] RESUME_LOAD = 4'(RESUME_CYC);
    localparam logic [`LCS_DATA_W-1:0] POL_RST = `LCS_POL_CFG_RST;

    // decoded refresh selection, reserved code treated as no refresh
    function automatic lcs_refresh_type ref_sel(input logic [1:0] code);
        ref_sel = (code == LCS_REF_RSVD) ? LCS_REF_NONE
                                         : lcs_refresh_type'(code);
    endfunction

    // palette window hit for an address
    function automatic logic pal_hit(input logic [`LCS_ADDR_W-1:0] a);
        pal_hit = (a & `LCS_PAL_MASK) == `LCS_ADDR_PAL_BASE;
    endfunction

    lcs_state_type             state_r;
    lcs_state_type             state_nxt;
    logic [`LCS_DATA_W-1:0]    psave_cfg_r;
    logic                      frame_pol_r;
    logic                      line_pol_r;
    logic [3:0]                resume_cnt_r;
    logic [PANEL_W-1:0]        panel_data_r;
    logic                      frame_pulse_r;
    logic                      line_pulse_r;
    logic                      pix_clk_r;
    logic                      pal_wr_n_r;
    logic                      pal_rd_n_r;
    logic [1:0]                pal_sel_r;
    logic [PAL_W-1:0]          pal_wdata_r;
    logic [1:0]                rd_src_r;
    logic [`LCS_DATA_W-1:0]    special_rdata_r;
    logic                      host_oe_r;
    logic                      mem_grant_r;
    logic                      mem_refused_r;
    logic [`LCS_DATA_W-1:0]    store_rdata;

    // state decode
    wire                  st_normal = (state_r == LCS_ST_NORMAL);
    wire                  st_sw     = (state_r == LCS_ST_SW);
    wire                  st_hw     = (state_r == LCS_ST_HW);
    wire                  suspended = !st_normal;
    wire lcs_refresh_type ref_mode  =
        ref_sel(psave_cfg_r[`LCS_REFSEL_HI:`LCS_REFSEL_LO]);
    wire                  ref_cbr   = (ref_mode == LCS_REF_CBR);
    wire                  sw_req    = psave_cfg_r[`LCS_SWSUSP_BIT];

    // register access acceptance
    wire addr_pal    = pal_hit(reg_addr);
    wire reg_allowed = st_normal || (st_sw && !addr_pal);          // R2 R3
    wire wr_ok       = reg_wr && reg_allowed;
    wire rd_ok       = reg_rd && reg_allowed;
    wire wr_psave    = wr_ok && (reg_addr == `LCS_ADDR_PSAVE_CFG);
    wire wr_frame    = wr_ok && (reg_addr == `LCS_ADDR_FRAME_CFG);
    wire wr_line     = wr_ok && (reg_addr == `LCS_ADDR_LINE_CFG);
    wire wr_pal      = wr_ok && addr_pal;
    wire rd_pal      = rd_ok && addr_pal;
    wire rd_stat     = rd_ok && (reg_addr == `LCS_ADDR_PSAVE_STAT);
    wire wr_store    = wr_ok && !addr_pal;
    wire rd_store    = rd_ok && !addr_pal && !rd_stat;

    // status word: state code, refresh mode, resume busy
    wire [`LCS_DATA_W-1:0] stat_word = {
        (resume_cnt_r != 4'h0), 2'h0, ref_mode, state_r
    };

    // power state selection, hardware request takes priority
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            LCS_ST_NORMAL: begin
                if (hw_suspend_req) begin
                    state_nxt = LCS_ST_HW;                          // R1
                end else if (sw_req) begin
                    state_nxt = LCS_ST_SW;                          // R1
                end
            end
            LCS_ST_SW: begin
                if (hw_suspend_req) begin
                    state_nxt = LCS_ST_HW;
                end else if (!sw_req) begin
                    state_nxt = LCS_ST_NORMAL;                      // R16
                end
            end
            LCS_ST_HW: begin
                if (!hw_suspend_req) begin
                    state_nxt = sw_req ? LCS_ST_SW : LCS_ST_NORMAL; // R16
                end
            end
            default: begin
                state_nxt = LCS_ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= LCS_ST_NORMAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // configuration bits kept across suspend
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            psave_cfg_r <= `LCS_PSAVE_CFG_RST;
            frame_pol_r <= POL_RST[`LCS_POL_BIT];
            line_pol_r  <= POL_RST[`LCS_POL_BIT];
        end else begin
            if (wr_psave) begin
                psave_cfg_r <= reg_wdata;                           // R12
            end
            if (wr_frame) begin
                frame_pol_r <= reg_wdata[`LCS_POL_BIT];             // R13
            end
            if (wr_line) begin
                line_pol_r <= reg_wdata[`LCS_POL_BIT];              // R13
            end
        end
    end

    // short settle time after leaving suspend before display resumes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            resume_cnt_r <= 4'h0;
        end else if (suspended) begin
            resume_cnt_r <= RESUME_LOAD;
        end else if (resume_cnt_r != 4'h0) begin
            resume_cnt_r <= resume_cnt_r - 4'h1;
        end
    end

    wire disp_run = st_normal && (resume_cnt_r == 4'h0);

    // panel outputs; polarity bit set means active high
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            panel_data_r  <= '0;
            frame_pulse_r <= 1'b0;
            line_pulse_r  <= 1'b0;
        end else if (disp_run) begin
            panel_data_r  <= pipe_panel_data;
            frame_pulse_r <= pipe_frame_pulse;
            line_pulse_r  <= pipe_line_pulse;
        end else begin
            panel_data_r  <= '0;                                    // R5
            frame_pulse_r <= !frame_pol_r;                          // R13
            line_pulse_r  <= !line_pol_r;                           // R13
        end
    end

    // palette pixel clock runs at half rate only while displaying
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pix_clk_r <= 1'b0;
        end else if (disp_run) begin
            pix_clk_r <= !pix_clk_r;
        end else begin
            pix_clk_r <= 1'b0;                                      // R14
        end
    end

    // palette converter strobes, one cycle per accepted access
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pal_wr_n_r  <= 1'b1;
            pal_rd_n_r  <= 1'b1;
            pal_sel_r   <= 2'h0;
            pal_wdata_r <= '0;
        end else begin
            pal_wr_n_r <= !wr_pal;                                  // R14
            pal_rd_n_r <= !rd_pal;                                  // R14
            if (wr_pal || rd_pal) begin
                pal_sel_r <= reg_addr[1:0];
            end
            if (wr_pal) begin
                pal_wdata_r <= reg_wdata;
            end
        end
    end

    // read source: 0 none, 1 store, 2 status, 3 palette
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_src_r        <= 2'h0;
            special_rdata_r <= '0;
            host_oe_r       <= 1'b0;
        end else begin
            rd_src_r  <= rd_store ? 2'h1 : rd_stat ? 2'h2
                       : rd_pal ? 2'h3 : 2'h0;
            host_oe_r <= rd_ok;                                     // R15
            if (rd_stat) begin
                special_rdata_r <= stat_word;
            end
        end
    end

    // palette read data sampled in the accepted read cycle, on the edge that drives its strobe low
    logic [PAL_W-1:0] pal_rdata_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pal_rdata_r <= '0;
        end else if (rd_pal) begin
            pal_rdata_r <= palette_rdata;
        end
    end

    // display memory access gating
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mem_grant_r   <= 1'b0;
            mem_refused_r <= 1'b0;
        end else begin
            mem_grant_r   <= host_mem_req && st_normal;             // R4
            mem_refused_r <= host_mem_req && !st_normal;            // R4
        end
    end

    lcs_reg_store #(
        .AW (`LCS_ADDR_W),
        .DW (`LCS_DATA_W)
    ) u_store (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .wr_en   (wr_store),                                        // R16
        .wr_addr (reg_addr),
        .wr_data (reg_wdata),
        .rd_en   (rd_store),
        .rd_addr (reg_addr),
        .rd_data (store_rdata)
    );

    // read data mux, registered sources only
    wire [`LCS_DATA_W-1:0] rdata_sel =
        (rd_src_r == 2'h1) ? store_rdata :
        (rd_src_r == 2'h2) ? special_rdata_r :
        (rd_src_r == 2'h3) ? pal_rdata_r : '0;

    assign reg_rdata   = host_oe_r ? rdata_sel : '0;                // R15
    assign host_out_en = host_oe_r;                                 // R15

    assign host_mem_grant   = mem_grant_r;
    assign host_mem_refused = mem_refused_r;

    assign panel_data          = panel_data_r;
    assign panel_frame_pulse   = frame_pulse_r;
    assign panel_line_pulse    = line_pulse_r;
    assign panel_power_control = st_normal;                         // R6
    assign display_active      = disp_run;                          // R5
    assign crt_out_en          = st_normal;                         // R7

    assign palette_write_strobe_n = pal_wr_n_r;
    assign palette_read_strobe_n  = pal_rd_n_r;
    assign palette_reg_select0    = pal_sel_r[0];
    assign palette_reg_select1    = pal_sel_r[1];
    assign palette_wdata          = pal_wdata_r;
    assign palette_pixel_clock    = pix_clk_r;                      // R14

    // internal module and clock enables per state and refresh scheme
    assign core_clk_en    = st_normal;                      // R8 R9 R10 R11
    assign host_if_clk_en = st_normal || st_sw;                     // R9 R10 R11
    assign mem_if_clk_en  = st_normal || ref_cbr;                   // R8 R9 R10

    // dram behaviour while suspended
    assign dram_refresh_only = suspended;                           // R12
    assign dram_cbr_refresh  = suspended && ref_cbr;                // R12
    assign dram_self_refresh = suspended
                             && (ref_mode == LCS_REF_SELF);         // R12

    assign power_save_state = state_r;
endmodule // lcs_suspend_ctl

// ===== lcs_suspend_ctl_asserts.sv
// checker for the suspend control block ports
`timescale 1ns/10ps
`include "lcs_map.svh"
module lcs_suspend_ctl_asserts
    import lcs_pkg::*;
#(
    parameter int PANEL_W = 16
) (
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    input wire logic [`LCS_ADDR_W-1:0] reg_addr,
    input wire logic                   reg_rd,
    input wire logic [`LCS_DATA_W-1:0] reg_rdata,
    input wire logic                   host_out_en,
    input wire logic                   host_mem_req,
    input wire logic                   host_mem_grant,
    input wire logic [PANEL_W-1:0]     panel_data,
    input wire logic                   panel_power_control,
    input wire logic                   display_active,
    input wire logic                   crt_out_en,
    input wire logic                   palette_pixel_clock,
    input wire logic                   core_clk_en,
    input wire logic                   host_if_clk_en,
    input wire logic                   mem_if_clk_en,
    input wire logic                   dram_refresh_only,
    input wire logic                   dram_cbr_refresh,
    input wire lcs_state_type          power_save_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire nrm = power_save_state == LCS_ST_NORMAL;
    wire hw  = power_save_state == LCS_ST_HW;
    wire sw  = power_save_state == LCS_ST_SW;
    wire pal = (reg_addr & `LCS_PAL_MASK) == `LCS_ADDR_PAL_BASE;

    a_power_crt_level: assert property (
        panel_power_control == nrm && crt_out_en == nrm)
        else $error("panel power or crt enable wrong");
    a_hw_read_refused: assert property (
        reg_rd && hw |=> !host_out_en && reg_rdata == '0)
        else $error("read served in hardware suspend");
    a_sw_pal_refused: assert property (
        reg_rd && sw && pal |=> !host_out_en)
        else $error("palette read served in software suspend");
    a_mem_suspend_off: assert property (
        host_mem_req && !nrm |=> !host_mem_grant)
        else $error("memory granted in suspend");
    a_panel_data_low: assert property (
        !nrm |-> !display_active ##1 panel_data == '0)
        else $error("panel data active in suspend");
    a_hw_clock_gate: assert property (
        hw |-> !core_clk_en && !host_if_clk_en
            && mem_if_clk_en == dram_cbr_refresh)
        else $error("clock enables wrong in hardware suspend");
    a_sw_clock_gate: assert property (
        sw |-> !core_clk_en && host_if_clk_en
            && mem_if_clk_en == dram_cbr_refresh)
        else $error("clock enables wrong in software suspend");
    a_refresh_only_set: assert property (
        dram_refresh_only == !nrm)
        else $error("refresh only flag wrong");
    a_pixel_clock_stop: assert property (
        !display_active |=> !palette_pixel_clock)
        else $error("pixel clock runs without display");

    c_hw_state: cover property (hw ##1 nrm);
    c_sw_state: cover property (sw ##1 nrm);
    c_pal_refused: cover property (reg_rd && sw && pal);
endmodule // lcs_suspend_ctl_asserts

bind lcs_suspend_ctl lcs_suspend_ctl_asserts #(.PANEL_W(PANEL_W))
    lcs_suspend_ctl_asserts_i (.sys_clk, .resetn, .reg_addr, .reg_rd,
    .reg_rdata, .host_out_en, .host_mem_req, .host_mem_grant, .panel_data,
    .panel_power_control, .display_active, .crt_out_en,
    .palette_pixel_clock, .core_clk_en, .host_if_clk_en, .mem_if_clk_en,
    .dram_refresh_only, .dram_cbr_refresh, .power_save_state);

// ===== lcs_pal_model.sv
// behavioural palette converter on the far side
`timescale 1ns/10ps
module lcs_pal_model (
    input  wire logic       sys_clk,
    input  wire logic       palette_write_strobe_n,
    input  wire logic       palette_reg_select0,
    input  wire logic       palette_reg_select1,
    input  wire logic [7:0] palette_wdata,
    output logic      [7:0] palette_rdata
);
    logic [7:0] mem_r [4];
    wire  [1:0] sel = {palette_reg_select1, palette_reg_select0};
    initial begin
        foreach (mem_r[i]) mem_r[i] = 8'h00;
    end
    always @(posedge sys_clk) begin
        if (!palette_write_strobe_n) begin
            mem_r[sel] <= palette_wdata;
        end
    end
    assign palette_rdata = mem_r[sel];
endmodule // lcs_pal_model

// ===== lcs_suspend_ctl_tb.sv
// testbench for the suspend control block
`timescale 1ns/10ps
module lcs_suspend_ctl_tb;
    import lcs_pkg::*;
    logic sys_clk, resetn, reg_wr, reg_rd, host_out_en, hw_suspend_req;
    logic host_mem_req, host_mem_grant, host_mem_refused, display_active;
    logic pipe_frame_pulse, pipe_line_pulse, panel_frame_pulse;
    logic panel_line_pulse, panel_power_control, crt_out_en;
    logic palette_write_strobe_n, palette_read_strobe_n;
    logic palette_reg_select0, palette_reg_select1, palette_pixel_clock;
    logic core_clk_en, host_if_clk_en, mem_if_clk_en, dram_refresh_only;
    logic dram_cbr_refresh, dram_self_refresh;
    logic [7:0]    reg_addr, reg_wdata, reg_rdata;
    logic [7:0]    palette_wdata, palette_rdata;
    logic [15:0]   pipe_panel_data, panel_data;
    lcs_state_type power_save_state;
    int            miscompares, n_compared;

    lcs_suspend_ctl lcs_suspend_ctl_i (.sys_clk, .resetn, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .host_out_en,
        .hw_suspend_req, .host_mem_req, .host_mem_grant, .host_mem_refused,
        .pipe_panel_data, .pipe_frame_pulse, .pipe_line_pulse, .panel_data,
        .panel_frame_pulse, .panel_line_pulse, .panel_power_control,
        .display_active, .crt_out_en, .palette_write_strobe_n,
        .palette_read_strobe_n, .palette_reg_select0, .palette_reg_select1,
        .palette_wdata, .palette_rdata, .palette_pixel_clock, .core_clk_en,
        .host_if_clk_en, .mem_if_clk_en, .dram_refresh_only,
        .dram_cbr_refresh, .dram_self_refresh, .power_save_state);
    lcs_pal_model lcs_pal_model_i (.sys_clk, .palette_write_strobe_n,
        .palette_reg_select0, .palette_reg_select1, .palette_wdata,
        .palette_rdata);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic en, logic [7:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(host_out_en, en);
        chk(reg_rdata, d);
    endtask

    task automatic t_normal();
        logic p;
        wr(8'h07, 8'h40);
        wr(8'h0C, 8'h00);
        wr(8'h55, 8'h3C);
        rd(8'h55, 1'b1, 8'h3C);
        cyc(1);
        chk(host_mem_grant, 1'b1);
        chk(panel_data, 16'h1234);
        chk({panel_power_control, crt_out_en, core_clk_en}, 3'h7);
        chk({panel_frame_pulse, panel_line_pulse}, 2'h3);
        p = palette_pixel_clock;
        cyc(1);
        chk(palette_pixel_clock, !p);
        wr(8'h31, 8'hA5);
        #1;
        chk({palette_write_strobe_n, palette_reg_select1,
             palette_reg_select0}, 3'h1);
        cyc(1);
        chk(palette_write_strobe_n, 1'b1);
        rd(8'h31, 1'b1, 8'hA5);
        chk(palette_read_strobe_n, 1'b0);
        $display("test normal done");
    endtask

    task automatic t_sw(logic [1:0] m);
        wr(8'h1A, {6'h20, m});
        cyc(4);
        chk(power_save_state, LCS_ST_SW);
        chk({panel_power_control, crt_out_en}, 2'h0);
        chk(panel_data, 16'h0);
        chk({panel_frame_pulse, panel_line_pulse}, 2'h2);
        chk({core_clk_en, host_if_clk_en, mem_if_clk_en}, {2'h1, m == 0});
        chk({dram_refresh_only, dram_cbr_refresh, dram_self_refresh},
            {1'b1, m == 0, m == 1});
        chk({host_mem_grant, host_mem_refused}, 2'h1);
        rd(8'h55, 1'b1, 8'h3C);
        rd(8'h32, 1'b0, 8'h00);
        chk(palette_read_strobe_n, 1'b1);
        rd(8'h2C, 1'b1, {3'h4, ((m == 2'h3) ? 2'h2 : m), 3'h2});
        wr(8'h1A, {6'h00, m});
        cyc(4);
        chk({power_save_state, display_active}, {LCS_ST_NORMAL, 1'b0});
        cyc(10);
        chk(display_active, 1'b1);
        $display("test software suspend done");
    endtask

    task automatic t_hw(logic [1:0] m);
        wr(8'h1A, {6'h00, m});
        hw_suspend_req <= 1'b1;
        cyc(4);
        chk(power_save_state, LCS_ST_HW);
        chk({core_clk_en, host_if_clk_en, mem_if_clk_en}, {2'h0, m == 0});
        chk({panel_power_control, crt_out_en, palette_pixel_clock}, 3'h0);
        chk(panel_data, 16'h0);
        rd(8'h55, 1'b0, 8'h00);
        wr(8'h55, 8'hFF);
        hw_suspend_req <= 1'b0;
        cyc(16);
        rd(8'h55, 1'b1, 8'h3C);
        $display("test hardware suspend done");
    endtask

    task automatic t_hw_to_sw();
        wr(8'h1A, 8'h80);
        hw_suspend_req <= 1'b1;
        cyc(4);
        chk(power_save_state, LCS_ST_HW);
        @(posedge sys_clk);
        hw_suspend_req <= 1'b0;
        cyc(4);
        chk(power_save_state, LCS_ST_SW);
        wr(8'h1A, 8'h00);
        cyc(16);
        $display("test hardware to software done");
    endtask

    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #20000;
        miscompares++;
        stop_test();
    end

    initial begin
        {resetn, reg_wr, reg_rd, hw_suspend_req} = '0;
        {reg_addr, reg_wdata} = '0;
        host_mem_req     = 1'b1;
        pipe_panel_data  = 16'h1234;
        pipe_frame_pulse = 1'b1;
        pipe_line_pulse  = 1'b1;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        cyc(1);
        chk(power_save_state, LCS_ST_NORMAL);
        cyc(12);
        t_normal();
        for (int m = 0; m < 4; m++) begin
            t_sw(m[1:0]);
            t_hw(m[1:0]);
        end
        t_hw_to_sw();
        stop_test();
    end
endmodule // lcs_suspend_ctl_tb
